// ---- design/tbpwm_pkg.sv ----
// constants, register indices and reset values of the ten-bit pwm output stage
package tbpwm_pkg;
  localparam int unsigned TBPWM_ADDR_W = 12;
  // register indices, byte address is four times the index
  localparam logic [7:0] TBPWM_IDX_FLAGS = 8'h0c;
  localparam logic [7:0] TBPWM_IDX_TMR = 8'h11;
  localparam logic [7:0] TBPWM_IDX_TCTL = 8'h12;
  localparam logic [7:0] TBPWM_IDX_DUTYL = 8'h15;
  localparam logic [7:0] TBPWM_IDX_DUTYH = 8'h16;
  localparam logic [7:0] TBPWM_IDX_CON = 8'h17;
  localparam logic [7:0] TBPWM_IDX_TRIS = 8'h87;
  localparam logic [7:0] TBPWM_IDX_PIE = 8'h8c;
  localparam logic [7:0] TBPWM_IDX_PR = 8'h92;
  // reset values
  localparam logic [7:0] TBPWM_RST_TRIS = 8'hff;
  localparam logic [7:0] TBPWM_RST_PIE = 8'h00;
  localparam logic [7:0] TBPWM_RST_PR = 8'hff;
  localparam logic [7:0] TBPWM_RST_ZERO = 8'h00;
  localparam logic [5:0] TBPWM_RST_FRAC = 6'h00;
  localparam logic [3:0] TBPWM_RST_POST = 4'h0;
  // field positions
  localparam int unsigned TBPWM_TRIS_PIN_BIT = 2;
  localparam int unsigned TBPWM_PIE_MATCH_BIT = 1;
  localparam int unsigned TBPWM_FLAG_MATCH_BIT = 1;
  localparam int unsigned TBPWM_CON_DLSB_LO = 4;
  localparam int unsigned TBPWM_CON_MODE_LO = 2;
  localparam int unsigned TBPWM_TCTL_PSC_LO = 0;
  localparam int unsigned TBPWM_TCTL_ON_BIT = 2;
  localparam int unsigned TBPWM_TCTL_POST_LO = 3;
  // mode and prescale encodings
  localparam logic [1:0] TBPWM_MODE_PWM = 2'h3;
  localparam logic [1:0] TBPWM_PSC_1 = 2'h0;
  localparam logic [1:0] TBPWM_PSC_4 = 2'h1;
  // last fine count per prescale: four oscillator cycles times prescale, minus one
  localparam logic [5:0] TBPWM_FRAC_MAX_1 = 6'h03;
  localparam logic [5:0] TBPWM_FRAC_MAX_4 = 6'h0f;
  localparam logic [5:0] TBPWM_FRAC_MAX_16 = 6'h3f;
endpackage

// ---- design/tbpwm_tb_if.sv ----
// time base signals between the pwm control logic and the period timer
`timescale 1ns/10ps
`default_nettype none
interface tbpwm_tb_if;
  logic run;
  logic [1:0] psc;
  logic [7:0] limit;
  logic cnt_wr;
  logic [7:0] cnt_wdata;
  logic [7:0] count;
  logic [7:0] count_next;
  logic [1:0] fine_next;
  logic tick;
  logic period_end;
  modport timebase (input run, psc, limit, cnt_wr, cnt_wdata, output count, count_next, fine_next, tick, period_end);
  modport ctrl (output run, psc, limit, cnt_wr, cnt_wdata, input count, count_next, fine_next, tick, period_end);
endinterface
`default_nettype wire

// ---- design/tbpwm_timebase.sv ----
// period timer with prescaler and quarter-phase fine count
`timescale 1ns/10ps
`default_nettype none
module tbpwm_timebase
  import tbpwm_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // time base link
  tbpwm_tb_if.timebase tb
);
  typedef struct packed {
    logic [5:0] frac;
    logic [7:0] count;
  } tbpwm_tbst_type;

  tbpwm_tbst_type s_q;
  tbpwm_tbst_type s_d;
  logic [5:0] frac_max;

  always_comb
  begin
    frac_max = TBPWM_FRAC_MAX_16;
    if (tb.psc == TBPWM_PSC_1)
    begin
      frac_max = TBPWM_FRAC_MAX_1;
    end
    else if (tb.psc == TBPWM_PSC_4)
    begin
      frac_max = TBPWM_FRAC_MAX_4;
    end
  end

  // one increment per four oscillator cycles times prescale
  assign tb.tick = tb.run && (s_q.frac == frac_max);
  assign tb.period_end = tb.tick && (s_q.count == tb.limit);
  // fine bits advance once per prescale oscillator cycles; next-cycle values are handed over
  // so the registered pin is already low in the cycle where the counts match
  assign tb.count_next = s_d.count;
  assign tb.fine_next = (tb.psc == TBPWM_PSC_1) ? s_d.frac[1:0] :
                        (tb.psc == TBPWM_PSC_4) ? s_d.frac[3:2] : s_d.frac[5:4];
  assign tb.count = s_q.count;

  always_comb
  begin
    s_d = s_q;
    if (tb.cnt_wr)
    begin
      // a software write also restarts the prescaler
      s_d.count = tb.cnt_wdata;
      s_d.frac = TBPWM_RST_FRAC;
    end
    else if (tb.run)
    begin
      s_d.frac = tb.tick ? TBPWM_RST_FRAC : s_q.frac + 6'h01;
      if (tb.period_end)
      begin
        s_d.count = TBPWM_RST_ZERO;
      end
      else if (tb.tick)
      begin
        s_d.count = s_q.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '{frac: TBPWM_RST_FRAC, count: TBPWM_RST_ZERO};
    end
    else
    begin
      s_q <= s_d;
    end
  end
endmodule // tbpwm_timebase
`default_nettype wire

// ---- design/tbpwm_top.sv ----
// ten-bit pwm output stage with its apb register file
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - pwm waveform on pin, ten-bit duty
// - all-zero control write forces output low
// - period is limit plus one, times four, prescale
// - period end clears timer, loads active duty
// - period end sets pin unless duty zero
// - postscaler only paces separate update event
// - duty is low buffer then control bits 5:4
// - high time is duty times oscillator times prescale
// - duty writes anytime, effective next period
// - active duty read-only in pwm mode
// - active duty plus hidden latch double buffer
// - pin low when duty equals extended count
// - duty beyond period keeps output high
// - period limit at 92h, resets all ones
module tbpwm_top
  import tbpwm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [TBPWM_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // pwm pin
  output logic PWM_OUT,
  output logic PWM_OUT_OE,
  // period match request level
  output logic PERIOD_MATCH_REQ
);
  typedef struct packed {
    logic [7:0] tris;
    logic [7:0] pie;
    logic [7:0] pr;
    logic [7:0] con;
    logic [7:0] duty_low;
    logic [7:0] duty_act;
    logic [1:0] latch2;
    logic [7:0] tctl;
    logic [3:0] post;
    logic flag;
    logic pin;
    logic [31:0] rdata;
    logic slverr;
  } tbpwm_state_type;

  tbpwm_state_type s_q;
  tbpwm_state_type s_d;
  tbpwm_tb_if tb_link ();

  logic [7:0] idx;
  logic aligned;
  logic hit;
  logic wr;
  logic setup;
  logic pwm_mode;
  logic [9:0] duty_next;
  logic [7:0] rbyte;
  logic [7:0] wbyte;

  assign idx = PADDR[9:2];
  assign aligned = (PADDR[1:0] == 2'h0) && (PADDR[TBPWM_ADDR_W-1:10] == 2'h0);
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE && hit && !s_q.slverr;
  assign wbyte = PWDATA[7:0];
  assign pwm_mode = s_q.con[TBPWM_CON_MODE_LO +: 2] == TBPWM_MODE_PWM;
  // buffered duty: low buffer on top, control bits below
  assign duty_next = {s_q.duty_low, s_q.con[TBPWM_CON_DLSB_LO +: 2]};

  always_comb
  begin
    hit = aligned;
    rbyte = TBPWM_RST_ZERO;
    case (idx)
      TBPWM_IDX_FLAGS: rbyte = {6'h00, s_q.flag, 1'b0};
      TBPWM_IDX_TMR: rbyte = tb_link.count;
      TBPWM_IDX_TCTL: rbyte = {1'b0, s_q.tctl[6:0]};
      TBPWM_IDX_DUTYL: rbyte = s_q.duty_low;
      TBPWM_IDX_DUTYH: rbyte = s_q.duty_act;
      TBPWM_IDX_CON: rbyte = {2'h0, s_q.con[5:0]};
      TBPWM_IDX_TRIS: rbyte = s_q.tris;
      TBPWM_IDX_PIE: rbyte = s_q.pie;
      TBPWM_IDX_PR: rbyte = s_q.pr;
      default: hit = 1'b0;
    endcase
  end

  // time base link
  assign tb_link.run = s_q.tctl[TBPWM_TCTL_ON_BIT];
  assign tb_link.psc = s_q.tctl[TBPWM_TCTL_PSC_LO +: 2];
  assign tb_link.limit = s_q.pr;
  assign tb_link.cnt_wr = wr && (idx == TBPWM_IDX_TMR);
  assign tb_link.cnt_wdata = wbyte;

  tbpwm_timebase u_timebase (
    .clk(CLK),
    .rst(RST),
    .tb(tb_link.timebase)
  );

  always_comb
  begin
    s_d = s_q;
    // read data and error are captured in the setup cycle so they come from flops
    if (setup)
    begin
      // refused accesses read as zero
      s_d.rdata = {24'h000000, hit ? rbyte : TBPWM_RST_ZERO};
      s_d.slverr = !hit;
    end
    if (wr)
    begin
      case (idx)
        TBPWM_IDX_FLAGS: s_d.flag = wbyte[TBPWM_FLAG_MATCH_BIT];
        TBPWM_IDX_TCTL: s_d.tctl = {1'b0, wbyte[6:0]};
        TBPWM_IDX_DUTYL: s_d.duty_low = wbyte;
        TBPWM_IDX_DUTYH:
        begin
          if (!pwm_mode)
          begin
            s_d.duty_act = wbyte;
          end
        end
        TBPWM_IDX_CON: s_d.con = {2'h0, wbyte[5:0]};
        TBPWM_IDX_TRIS: s_d.tris = wbyte;
        TBPWM_IDX_PIE: s_d.pie = wbyte;
        TBPWM_IDX_PR: s_d.pr = wbyte;
        default: s_d.flag = s_q.flag;
      endcase
    end
    if (tb_link.period_end)
    begin
      // new duty only at the period boundary keeps the output glitch free
      s_d.duty_act = s_q.duty_low;
      s_d.latch2 = s_q.con[TBPWM_CON_DLSB_LO +: 2];
      // postscaler paces the update event only, never the pwm period
      if (s_q.post == s_q.tctl[TBPWM_TCTL_POST_LO +: 4])
      begin
        s_d.post = TBPWM_RST_POST;
        s_d.flag = 1'b1;
      end
      else
      begin
        s_d.post = s_q.post + 4'h1;
      end
    end
    // pwm output latch
    if (!pwm_mode)
    begin
      s_d.pin = 1'b0;
    end
    else if (tb_link.period_end)
    begin
      s_d.pin = duty_next != 10'h000;
    end
    else if ({s_q.duty_act, s_q.latch2} == {tb_link.count_next, tb_link.fine_next})
    begin
      // a duty above the period never matches, so the pin stays high
      s_d.pin = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      s_q <= '{tris: TBPWM_RST_TRIS, pie: TBPWM_RST_PIE, pr: TBPWM_RST_PR, con: TBPWM_RST_ZERO,
               duty_low: TBPWM_RST_ZERO, duty_act: TBPWM_RST_ZERO, latch2: 2'h0, tctl: TBPWM_RST_ZERO,
               post: TBPWM_RST_POST, flag: 1'b0, pin: 1'b0, rdata: 32'h00000000, slverr: 1'b0};
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // zero wait states: the answer comes in the first access cycle
  assign PREADY = 1'b1;
  assign PRDATA = s_q.rdata;
  assign PSLVERR = PSEL && PENABLE && s_q.slverr;
  assign PWM_OUT = s_q.pin;
  // pin reaches the load only while software holds the direction bit clear
  assign PWM_OUT_OE = !s_q.tris[TBPWM_TRIS_PIN_BIT];
  assign PERIOD_MATCH_REQ = s_q.flag && s_q.pie[TBPWM_PIE_MATCH_BIT];
endmodule // tbpwm_top
`default_nettype wire

// ---- design/tbpwm_tb_if_unused_placeholder.sv ----
// intentionally empty compile unit
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ---- verification/tbpwm_asserts.sv ----
// port checker for the pwm stage
`timescale 1ns/10ps
`default_nettype none
module tbpwm_asserts
  import tbpwm_pkg::*;
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [TBPWM_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // pin
  input wire logic PWM_OUT,
  input wire logic PWM_OUT_OE,
  input wire logic PERIOD_MATCH_REQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // shadow of the control register, mode is judged from software writes
  logic [7:0] con_q;
  sequence s_wr(idx);
    PSEL && PENABLE && PWRITE && PADDR == {2'h0, idx, 2'h0};
  endsequence
  always_ff @(posedge CLK or posedge RST)
    if (RST)
      con_q <= 8'h00;
    else if (PSEL && PENABLE && PWRITE && PADDR == {2'h0, TBPWM_IDX_CON, 2'h0})
      con_q <= PWDATA[7:0];
  a_ready_high: assert property (PREADY) else $error("pready low");
  a_err_access: assert property (PSLVERR |-> PSEL && PENABLE) else $error("late error");
  a_misalign_err: assert property (PSEL && PENABLE && PADDR[1:0] != 2'h0 |-> PSLVERR) else $error("no error");
  a_rdata_upper: assert property (PSEL && PENABLE |-> PRDATA[31:8] == 24'h0) else $error("upper data");
  a_dir_oe: assert property (s_wr(TBPWM_IDX_TRIS) |=> PWM_OUT_OE == !$past(PWDATA[2])) else $error("oe");
  a_clear_low: assert property (s_wr(TBPWM_IDX_CON) ##0 PWDATA[7:0] == 8'h00 |=> ##1 !PWM_OUT [*4])
    else $error("pin not cleared");
  a_mode_low: assert property (con_q[3:2] != TBPWM_MODE_PWM && $past(con_q[3:2]) != TBPWM_MODE_PWM |-> !PWM_OUT)
    else $error("pin high out of mode");
  a_req_gate: assert property (s_wr(TBPWM_IDX_PIE) ##0 !PWDATA[1] |=> !PERIOD_MATCH_REQ)
    else $error("request not gated");
endmodule // tbpwm_asserts
bind tbpwm_top tbpwm_asserts u_asserts (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT),
  .PWM_OUT_OE(PWM_OUT_OE), .PERIOD_MATCH_REQ(PERIOD_MATCH_REQ));
`default_nettype wire

// ---- verification/tbpwm_load.sv ----
// load on the pwm pin with a weak pull-down
`timescale 1ns/10ps
`default_nettype none
module tbpwm_load
(
  // pin
  input wire logic drive,
  input wire logic oe,
  output logic level
);
  // a released pin falls to the pull-down, never keeps the last level
  assign level = oe ? drive : 1'b0;
endmodule // tbpwm_load
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the pwm stage
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import tbpwm_pkg::*;
  logic CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, PWM_OUT, oe, req, pin, pin_d = 0;
  logic [TBPWM_ADDR_W-1:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA;
  logic [32:0] rq[$];
  int n_fail = 0, n_checks = 0, cyc = 0, hi = 0, lo = 0, seed = 44939, p, d, qh[$], ql[$];
  always #10 CLK = ~CLK;
  tbpwm_top DUT (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT),
    .PWM_OUT_OE(oe), .PERIOD_MATCH_REQ(req));
  tbpwm_load u_load (.drive(PWM_OUT), .oe(oe), .level(pin));
  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] wd, input logic [1:0] lsb);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {2'h0, idx, lsb};
    PWDATA <= {24'h0, wd};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd(input logic err, input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] lsb);
    rq.push_back({err, 24'h0, exp});
    apb(1'b0, idx, 8'h00, lsb);
  endtask
  // sampled before the edge lands, so stimulus updates never race the watcher
  always @(posedge CLK)
  begin
    cyc++;
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && rq.size() > 0)
      check("read", {PSLVERR, PRDATA}, rq.pop_front());
    if (pin && !pin_d && ql.size() > 0)
      check("low time", 33'(lo), 33'(ql.pop_front()));
    if (!pin && pin_d && qh.size() > 0)
      check("high time", 33'(hi), 33'(qh.pop_front()));
    hi = pin ? (pin_d ? hi + 1 : 1) : hi;
    lo = !pin ? (!pin_d ? lo + 1 : 1) : lo;
    pin_d = pin;
    if (cyc == 40000)
    begin
      n_fail++;
      end_sim;
    end
  end
  initial
  begin
    repeat (5) @(posedge CLK);
    RST <= 1'b0;
    rd(1'b0, TBPWM_IDX_TRIS, TBPWM_RST_TRIS, 2'h0);
    rd(1'b0, TBPWM_IDX_PIE, TBPWM_RST_PIE, 2'h0);
    rd(1'b0, TBPWM_IDX_PR, TBPWM_RST_PR, 2'h0);
    rd(1'b1, TBPWM_IDX_PR, 8'h00, 2'h1);
    apb(1'b1, TBPWM_IDX_TRIS, 8'hfb, 2'h0);
    apb(1'b1, TBPWM_IDX_PR, 8'h03, 2'h0);
    // one pass per prescale, duty written first, then the whole period after the next rising edge is timed
    for (int s = 0; s < 3; s++)
    begin
      p = 1 << (2 * s);
      d = ($random(seed) & 7) + 4;
      apb(1'b1, TBPWM_IDX_DUTYL, 8'(d >> 2), 2'h0);
      apb(1'b1, TBPWM_IDX_CON, {2'h0, 2'(d), 4'hc}, 2'h0);
      apb(1'b1, TBPWM_IDX_TCTL, {5'h0, 1'b1, 2'(s)}, 2'h0);
      do @(posedge CLK); while (pin !== 1'b0);
      do @(posedge CLK); while (pin !== 1'b1);
      @(posedge CLK);
      qh.push_back(d * p);
      ql.push_back(16 * p - d * p);
      while (qh.size() + ql.size() > 0) @(posedge CLK);
    end
    apb(1'b1, TBPWM_IDX_DUTYH, 8'h55, 2'h0);
    rd(1'b0, TBPWM_IDX_DUTYH, 8'(d >> 2), 2'h0);
    apb(1'b1, TBPWM_IDX_PIE, 8'h02, 2'h0);
    repeat (600) @(posedge CLK);
    check("request", 33'(req), 33'h1);
    rd(1'b0, TBPWM_IDX_FLAGS, 8'h02, 2'h0);
    apb(1'b1, TBPWM_IDX_PIE, 8'h00, 2'h0);
    // the write lands at the access edge, so look one edge later
    @(posedge CLK);
    check("request", 33'(req), 33'h0);
    apb(1'b1, TBPWM_IDX_TCTL, 8'h04, 2'h0);
    // control cleared, duty beyond the period, duty zero
    for (int k = 0; k < 3; k++)
    begin
      apb(1'b1, TBPWM_IDX_DUTYL, k == 1 ? 8'hff : 8'h00, 2'h0);
      apb(1'b1, TBPWM_IDX_CON, k == 0 ? 8'h00 : (k == 1 ? 8'h3c : 8'h0c), 2'h0);
      repeat (40) @(posedge CLK);
      repeat (32) @(posedge CLK) check("pin", 33'(pin), 33'(k == 1));
    end
    end_sim;
  end
endmodule // testbench
`default_nettype wire
